// [hw/pin_port.sv]
// One I/O port: pin control, alternate function overrides, sleep gating, bus slave
// Summary of operation
// - Deep sleep gating clamps each non-interrupt pin's digital input to ground before Schmitt trigger.
// - Gating is active only in power-down, power-save or standby sleep.
// - Pins with external interrupt enabled are never clamped; input stays live.
// - Pins with external interrupt disabled are clamped like any other pin.
// - Clamp release on wake makes an edge; the pin change flag records it.
// - Every pull-up is off while reset is active.
// - Without override, pull-up on only for direction 0, output 1, global disable 0.
// - With pull-up override enabled, pull-up equals the override value.
// - Driver enable comes from direction override when enabled, else direction bit.
// - With direction override enabled, driver enable equals the override value.
// - Driven level is value override when enabled, else the output bit.
// - Value override enable forces the pin value to the override value.
// - Toggle override enable inverts the pin's output bit.
// - Input enable override selects input enable; otherwise sleep state decides.
// - With input enable override, input enabled exactly when override value high.
// - Raw input to peripherals is taken after Schmitt, before the synchroniser.
// - Analog path connects straight to the pad, bypassing digital gating.
// - Strobes shared per port; clock, sleep, pull-up disable shared; overrides per pin.
// - Writing one to a pin input bit inverts that pin's output bit.
// - Input bit goes through a latch-plus-flop synchroniser, half to 1.5 clocks.
// - All pins tri-state as soon as reset is active, even without clock.
`timescale 1ns/100ps
module pin_port
    import pin_port_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Sleep controller, shared by all ports
    input wire logic sleep_active,
    input wire logic [SLEEP_MODE_W-1:0] sleep_mode,
    // External interrupt enables, per pin
    input wire logic [WIDTH-1:0] ext_int_en,
    // Alternate function overrides, per pin
    input wire logic [WIDTH-1:0] pullup_override_en,
    input wire logic [WIDTH-1:0] pullup_override_val,
    input wire logic [WIDTH-1:0] direction_override_en,
    input wire logic [WIDTH-1:0] direction_override_val,
    input wire logic [WIDTH-1:0] outvalue_override_en,
    input wire logic [WIDTH-1:0] outvalue_override_val,
    input wire logic [WIDTH-1:0] toggle_override_en,
    input wire logic [WIDTH-1:0] input_enable_override_en,
    input wire logic [WIDTH-1:0] input_enable_override_val,
    // To peripherals
    output logic [WIDTH-1:0] raw_digital_input,
    output logic [WIDTH-1:0] analog_pad_path,
    // Pad
    input wire logic [WIDTH-1:0] pad_in,
    output logic [WIDTH-1:0] pad_out,
    output logic [WIDTH-1:0] pad_oe,
    output logic [WIDTH-1:0] pullup_en
);

    // Register state
    logic [WIDTH-1:0] pin_direction_bit_reg;
    logic [WIDTH-1:0] pin_output_bit_reg;
    logic [WIDTH-1:0] pin_output_bit_next;
    logic [WIDTH-1:0] pin_input_bit_reg;
    logic [WIDTH-1:0] sync_low_reg;
    logic [WIDTH-1:0] pin_change_reg;
    logic [WIDTH-1:0] pin_input_prev_reg;
    logic global_pullup_disable_reg;
    logic [1:0] primed_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic ack_reg;

    // Bus decode
    wire logic bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    // Writes land at the edge where the master samples ack high, not before
    wire logic bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    wire logic bus_rd = bus_req && !wb_we_i;
    wire logic hit_input = (wb_adr_i == OFS_PIN_INPUT);
    wire logic hit_direction = (wb_adr_i == OFS_PIN_DIRECTION);
    wire logic hit_output = (wb_adr_i == OFS_PIN_OUTPUT);
    wire logic hit_control = (wb_adr_i == OFS_PORT_CONTROL);
    wire logic hit_change = (wb_adr_i == OFS_PIN_CHANGE);
    // One strobe set serves every pin of the port
    wire logic port_write_output_strobe = bus_wr && hit_output;
    wire logic port_read_output_strobe = bus_rd && hit_output;
    wire logic port_write_dir_strobe = bus_wr && hit_direction;
    wire logic port_write_pin_strobe = bus_wr && hit_input;
    wire logic port_write_change_strobe = bus_wr && hit_change;
    wire logic port_write_ctrl_strobe = bus_wr && hit_control && wb_sel_i[0];

    // Byte enables widened to one bit per pin
    logic [WIDTH-1:0] wmask;
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            wmask[i] = wb_sel_i[i / 8];
        end
    end
    wire logic [WIDTH-1:0] wdata = wb_dat_i[WIDTH-1:0];

    // Sleep gating only in the deep modes; idle keeps inputs live
    wire logic deep_mode = (sleep_mode == SLEEP_POWER_DOWN) ||
        (sleep_mode == SLEEP_POWER_SAVE) || (sleep_mode == SLEEP_STANDBY);
    wire logic sleep_gate = sleep_active && deep_mode;

    // Interrupt-enabled pins escape the clamp, others do not
    wire logic [WIDTH-1:0] sleep_clamp = {WIDTH{sleep_gate}} & ~ext_int_en;
    // Override decides input enable, else sleep state
    wire logic [WIDTH-1:0] input_enable = (input_enable_override_en & input_enable_override_val)
        | (~input_enable_override_en & ~sleep_clamp);

    // Clamp to ground ahead of the Schmitt trigger
    wire logic [WIDTH-1:0] schmitt_out = pad_in & input_enable;

    // Driver enable from override or direction bit
    wire logic [WIDTH-1:0] drive_en = (direction_override_en & direction_override_val)
        | (~direction_override_en & pin_direction_bit_reg);
    // Driven level from override or output bit
    wire logic [WIDTH-1:0] drive_val = (outvalue_override_en & outvalue_override_val)
        | (~outvalue_override_en & pin_output_bit_reg);
    // Default pull-up needs direction 0, output 1, global disable 0
    wire logic [WIDTH-1:0] pullup_plain = ~pin_direction_bit_reg & pin_output_bit_reg
        & {WIDTH{!global_pullup_disable_reg}};
    wire logic [WIDTH-1:0] pullup_sel = (pullup_override_en & pullup_override_val)
        | (~pullup_override_en & pullup_plain);

    // Pad side is combinational so overrides reach the pad without a clock edge,
    // and reset tri-states the pins with no clock needed
    always_comb begin
        pad_oe = rst ? '0 : drive_en;
        pad_out = rst ? '0 : drive_val;
        pullup_en = rst ? '0 : pullup_sel;
        raw_digital_input = schmitt_out;
        analog_pad_path = pad_in;
    end

    // Output bit: bus write, else toggle by input-bit write or peripheral
    wire logic [WIDTH-1:0] toggle_mask = (port_write_pin_strobe ? (wdata & wmask) : '0)
        | toggle_override_en;
    always_comb begin
        pin_output_bit_next = pin_output_bit_reg ^ toggle_mask;
        if (port_write_output_strobe) begin
            pin_output_bit_next = (wdata & wmask) | (pin_output_bit_reg & ~wmask);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_output_bit_reg <= '0;
            pin_direction_bit_reg <= '0;
            global_pullup_disable_reg <= CTRL_PULLUP_DISABLE_RESET;
        end else begin
            pin_output_bit_reg <= pin_output_bit_next;
            if (port_write_dir_strobe) begin
                pin_direction_bit_reg <= (wdata & wmask) | (pin_direction_bit_reg & ~wmask);
            end
            if (port_write_ctrl_strobe) begin
                global_pullup_disable_reg <= wb_dat_i[CTRL_PULLUP_DISABLE_BIT];
            end
        end
    end

    // Falling-edge stage stands in for the latch closed while clock is low
    always_ff @(negedge clock) begin
        if (rst) begin
            sync_low_reg <= '0;
        end else begin
            sync_low_reg <= schmitt_out;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_input_bit_reg <= '0;
        end else begin
            pin_input_bit_reg <= sync_low_reg;
        end
    end

    // Reset zeros sit in the synchroniser for two edges; a high pin would
    // otherwise raise a false change flag straight after reset
    always_ff @(posedge clock) begin
        if (rst) begin
            primed_reg <= '0;
        end else begin
            primed_reg <= {primed_reg[0], 1'b1};
        end
    end

    // Change flags; a change in the clear cycle still sets the flag.
    // Release of the clamp on wake shows up here as a change
    wire logic [WIDTH-1:0] pin_changed = (pin_input_bit_reg ^ pin_input_prev_reg)
        & {WIDTH{primed_reg[1]}};
    wire logic [WIDTH-1:0] change_clear = port_write_change_strobe ? (wdata & wmask) : '0;
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_input_prev_reg <= '0;
            pin_change_reg <= '0;
        end else begin
            pin_input_prev_reg <= pin_input_bit_reg;
            pin_change_reg <= (pin_change_reg & ~change_clear) | pin_changed;
        end
    end

    // Read mux; unmapped offsets answer zero
    wire logic [WIDTH-1:0] rd_pins = hit_input ? pin_input_bit_reg
        : hit_direction ? pin_direction_bit_reg
        : port_read_output_strobe ? pin_output_bit_reg
        : hit_change ? pin_change_reg : '0;
    wire logic [DATA_W-1:0] rd_word = hit_control
        ? {{(DATA_W-1){1'b0}}, global_pullup_disable_reg}
        : {{(DATA_W-WIDTH){1'b0}}, rd_pins};

    // Answer one cycle after the request, ack held a single cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= bus_req;
            if (bus_rd) begin
                rdata_reg <= rd_word;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Checks
    chk_sleep_clamp: assert property (@(posedge clock) disable iff (rst)
        ((({WIDTH{sleep_active && deep_mode}} & ~ext_int_en & ~input_enable_override_en)
        & raw_digital_input) == '0))
        else $error("clamped pin shows a high input");

    chk_idle_live: assert property (@(posedge clock) disable iff (rst)
        (sleep_mode == SLEEP_IDLE && input_enable_override_en == '0)
        |-> raw_digital_input == pad_in)
        else $error("input gated outside deep sleep");

    chk_int_live: assert property (@(posedge clock) disable iff (rst)
        ((ext_int_en & ~input_enable_override_en & (raw_digital_input ^ pad_in)) == '0))
        else $error("interrupt pin input not live");

    chk_pullup_reset: assert property (@(posedge clock)
        rst |-> (pullup_en == '0 && pad_oe == '0))
        else $error("pull-up or driver active in reset");

    chk_pullup_plain: assert property (@(posedge clock) disable iff (rst)
        ((~pullup_override_en & (pullup_en ^ (~pin_direction_bit_reg & pin_output_bit_reg
        & {WIDTH{!global_pullup_disable_reg}}))) == '0))
        else $error("default pull-up mismatch");

    chk_pullup_ovr: assert property (@(posedge clock) disable iff (rst)
        ((pullup_override_en & (pullup_en ^ pullup_override_val)) == '0))
        else $error("pull-up override ignored");

    chk_dir_ovr: assert property (@(posedge clock) disable iff (rst)
        ((direction_override_en & (pad_oe ^ direction_override_val)) == '0)
        && ((~direction_override_en & (pad_oe ^ pin_direction_bit_reg)) == '0))
        else $error("driver enable source wrong");

    chk_value_ovr: assert property (@(posedge clock) disable iff (rst)
        ((outvalue_override_en & (pad_out ^ outvalue_override_val)) == '0)
        && ((~outvalue_override_en & (pad_out ^ pin_output_bit_reg)) == '0))
        else $error("driven level source wrong");

    chk_toggle_ovr: assert property (@(posedge clock) disable iff (rst)
        (!port_write_output_strobe && !port_write_pin_strobe)
        |=> pin_output_bit_reg == ($past(pin_output_bit_reg) ^ $past(toggle_override_en)))
        else $error("toggle override did not invert");

    chk_pin_toggle: assert property (@(posedge clock) disable iff (rst)
        (port_write_pin_strobe && toggle_override_en == '0)
        |=> pin_output_bit_reg == ($past(pin_output_bit_reg) ^ $past(wdata & wmask)))
        else $error("input bit write did not toggle");

    chk_sync_delay: assert property (@(posedge clock) disable iff (rst)
        $stable(raw_digital_input) |=> pin_input_bit_reg == $past(raw_digital_input))
        else $error("synchroniser delay wrong");

    chk_bus_ack: assert property (@(posedge clock) disable iff (rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");

    chk_shallow_live: assert property (@(posedge clock) disable iff (rst)
        (!(sleep_active && deep_mode) && input_enable_override_en == '0)
        |-> raw_digital_input == pad_in)
        else $error("input gated while awake");

    chk_int_off_clamp: assert property (@(posedge clock) disable iff (rst)
        (sleep_active && deep_mode && ext_int_en == '0 && input_enable_override_en == '0)
        |-> raw_digital_input == '0)
        else $error("disabled interrupt pin not clamped");

    chk_ie_override: assert property (@(posedge clock) disable iff (rst)
        ((input_enable_override_en & ~input_enable_override_val & raw_digital_input) == '0)
        && ((input_enable_override_en & input_enable_override_val
        & (raw_digital_input ^ pad_in)) == '0))
        else $error("input enable override ignored");

    chk_raw_tap: assert property (@(posedge clock) disable iff (rst)
        ((raw_digital_input & ~pad_in) == '0))
        else $error("raw input high on a low pad");

    chk_analog_path: assert property (@(posedge clock)
        analog_pad_path == pad_in)
        else $error("analog path not tied to pad");

    chk_pad_tristate: assert property (@(posedge clock)
        rst |-> (pad_oe == '0 && pad_out == '0))
        else $error("pad driven in reset");

    chk_flag_set: assert property (@(posedge clock) disable iff (rst)
        (pin_changed != '0)
        |=> ((pin_change_reg & $past(pin_changed)) == $past(pin_changed)))
        else $error("pin change not flagged");

    chk_flag_clear: assert property (@(posedge clock) disable iff (rst)
        (change_clear != '0)
        |=> ((pin_change_reg & $past(change_clear & ~pin_changed)) == '0))
        else $error("pin change flag not cleared");

    chk_ctrl_write: assert property (@(posedge clock) disable iff (rst)
        port_write_ctrl_strobe
        |=> global_pullup_disable_reg == $past(wb_dat_i[CTRL_PULLUP_DISABLE_BIT]))
        else $error("global pull-up disable write lost");

    chk_ack_single: assert property (@(posedge clock) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    chk_out_write: assert property (@(posedge clock) disable iff (rst)
        port_write_output_strobe |=> pin_output_bit_reg
        == (($past(wdata) & $past(wmask)) | ($past(pin_output_bit_reg) & ~$past(wmask))))
        else $error("output write did not land");

    chk_dir_write: assert property (@(posedge clock) disable iff (rst)
        port_write_dir_strobe |=> pin_direction_bit_reg
        == (($past(wdata) & $past(wmask)) | ($past(pin_direction_bit_reg) & ~$past(wmask))))
        else $error("direction write did not land");

    chk_unmapped_read: assert property (@(posedge clock) disable iff (rst)
        (bus_rd && !(hit_input || hit_direction || hit_output || hit_control || hit_change))
        |=> wb_dat_o == '0)
        else $error("unmapped read not zero");

    chk_rd_direction: assert property (@(posedge clock) disable iff (rst)
        (bus_rd && hit_direction)
        |=> wb_dat_o == $past({{(DATA_W-WIDTH){1'b0}}, pin_direction_bit_reg}))
        else $error("direction read back wrong");

    chk_rd_input: assert property (@(posedge clock) disable iff (rst)
        (bus_rd && hit_input)
        |=> wb_dat_o == $past({{(DATA_W-WIDTH){1'b0}}, pin_input_bit_reg}))
        else $error("input bits read back wrong");

    cov_wake_edge: cover property (@(posedge clock) disable iff (rst)
        sleep_gate ##1 !sleep_gate ##3 (pin_change_reg != '0));
    cov_int_sleep: cover property (@(posedge clock) disable iff (rst)
        sleep_gate && (ext_int_en & raw_digital_input) != '0);
    cov_toggle: cover property (@(posedge clock) disable iff (rst)
        toggle_override_en != '0);
    cov_pullup: cover property (@(posedge clock) disable iff (rst)
        pullup_en != '0 && pullup_override_en == '0);
    cov_ie_sleep: cover property (@(posedge clock) disable iff (rst)
        sleep_gate && (input_enable_override_en & input_enable_override_val) != '0);

endmodule

// [hw/pin_port_pkg.sv]
// Register map, sleep mode codes and field positions for the pin port block
package pin_port_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_PIN_INPUT = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PIN_DIRECTION = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PIN_OUTPUT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PORT_CONTROL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PIN_CHANGE = 8'h10;
    localparam int CTRL_PULLUP_DISABLE_BIT = 0;
    localparam logic CTRL_PULLUP_DISABLE_RESET = 1'b0;
    localparam int SLEEP_MODE_W = 3;
    localparam logic [SLEEP_MODE_W-1:0] SLEEP_IDLE = 3'h0;
    localparam logic [SLEEP_MODE_W-1:0] SLEEP_ADC_NOISE = 3'h1;
    localparam logic [SLEEP_MODE_W-1:0] SLEEP_POWER_DOWN = 3'h2;
    localparam logic [SLEEP_MODE_W-1:0] SLEEP_POWER_SAVE = 3'h3;
    localparam logic [SLEEP_MODE_W-1:0] SLEEP_STANDBY = 3'h6;
endpackage

// [dv/pad_model.sv]
// Pad and peripheral side model: resolves pad level, resynchronises raw input
`timescale 1ns/100ps
module pad_model (
    // Clock
    input wire logic clock,
    // Port side
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] raw_digital_input,
    // External drivers set by the bench
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Resolved pad and peripheral view
    output logic [7:0] pad_in,
    output logic [7:0] periph_sync
);
    logic [7:0] float_reg = 8'h55;
    logic [7:0] stage_reg = 8'h00;
    // Undriven pad wanders, so no test may lean on a floating level
    always @(posedge clock) begin
        float_reg <= ~float_reg;
    end
    // Port driver wins, then external driver, then pull-up, else wander
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en & (pullup_en | float_reg));
    // Own two-stage synchroniser, raw input is asynchronous
    always @(posedge clock) begin
        stage_reg <= raw_digital_input;
        periph_sync <= stage_reg;
    end
endmodule

// [dv/port_pin_override_logic_tb.sv]
// Self-checking bench for the pin port: bus access, overrides, sleep gating
`timescale 1ns/100ps
module port_pin_override_logic_tb;
    import pin_port_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [ADDR_W-1:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [DATA_W-1:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, sleep_active = 1'b0;
    logic [SLEEP_MODE_W-1:0] sleep_mode = SLEEP_IDLE;
    logic [7:0] ext_int_en = 8'h00, pu_en = 8'h00, pu_val = 8'h00, dir_en = 8'h00;
    logic [7:0] dir_val = 8'h00, ov_en = 8'h00, ov_val = 8'h00, tog_en = 8'h00;
    logic [7:0] ie_en = 8'h00, ie_val = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0] raw, analog, pad_in, pad_out, pad_oe, pullup_en, exp8, psync;
    logic [SLEEP_MODE_W-1:0] modes [5] = '{SLEEP_IDLE, SLEEP_ADC_NOISE, SLEEP_POWER_DOWN,
        SLEEP_POWER_SAVE, SLEEP_STANDBY};
    int n_errors = 0;
    int compares = 0;
    // Peripheral overrides come from the bench, enable and value per pin, toggle enable alone
    pin_port #(.WIDTH(8)) dut (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sleep_active(sleep_active), .sleep_mode(sleep_mode), .ext_int_en(ext_int_en),
        .pullup_override_en(pu_en), .pullup_override_val(pu_val),
        .direction_override_en(dir_en), .direction_override_val(dir_val),
        .outvalue_override_en(ov_en), .outvalue_override_val(ov_val),
        .toggle_override_en(tog_en), .input_enable_override_en(ie_en),
        .input_enable_override_val(ie_val), .raw_digital_input(raw),
        .analog_pad_path(analog), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pullup_en(pullup_en));
    pad_model partner (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
        .pullup_en(pullup_en), .raw_digital_input(raw), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in), .periph_sync(psync));
    always #2 clock = ~clock;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // Classic single cycle; entered just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) check(1'b0, 1'b1, "ack timeout");
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clock);
    endtask
    task wrap_up;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        check({pad_oe, pad_out, pullup_en}, 24'h0, "pads in reset");
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Pull-up truth table over direction, output and global disable
        for (int i = 0; i < 8; i++) begin
            xfer(OFS_PIN_DIRECTION, 1'b1, {24'h0, {8{i[2]}}});
            xfer(OFS_PIN_OUTPUT, 1'b1, {24'h0, {8{i[1]}}});
            xfer(OFS_PORT_CONTROL, 1'b1, {31'h0, i[0]});
            @(negedge clock);
            check(pullup_en, (i == 2) ? 8'hFF : 8'h00, "pull-up");
            @(posedge clock);
        end
        xfer(OFS_PORT_CONTROL, 1'b1, 32'h0);
        pu_en <= 8'h0F;
        pu_val <= 8'h05;
        @(negedge clock);
        check(pullup_en, 8'h05, "pull-up override");
        @(posedge clock);
        pu_en <= 8'h00;
        xfer(OFS_PIN_OUTPUT, 1'b1, 32'hA5);
        @(negedge clock);
        check({pad_oe, pad_out}, 16'hFFA5, "driver");
        @(posedge clock);
        ov_en <= 8'h0F;
        ov_val <= 8'h03;
        dir_en <= 8'hF0;
        dir_val <= 8'h30;
        @(negedge clock);
        check({pad_oe, pad_out}, 16'h3FA3, "overrides");
        check(analog, pad_in, "analog path");
        @(posedge clock);
        {ov_en, dir_en} <= 16'h0;
        xfer(OFS_PIN_INPUT, 1'b1, 32'h02);
        tog_en <= 8'h01;
        @(posedge clock);
        tog_en <= 8'h00;
        xfer(OFS_PIN_OUTPUT, 1'b0, 32'h0);
        check(q, 32'hA6, "toggles");
        xfer(OFS_PIN_DIRECTION, 1'b1, 32'h0);
        ext_en <= 8'hFF;
        ext_val <= 8'h5A;
        @(negedge clock);
        check(raw, 8'h5A, "raw input");
        check(analog, 8'h5A, "analog follows pad");
        @(posedge clock);
        xfer(OFS_PIN_INPUT, 1'b0, 32'h0);
        check(q, 32'h5A, "synced input");
        check(psync, 8'h5A, "peripheral resync");
        ext_val <= 8'hFF;
        repeat (4) @(posedge clock);
        xfer(OFS_PIN_CHANGE, 1'b1, 32'hFF);
        // Sleep gating per mode, with interrupt pins and input enable overrides
        ext_int_en <= 8'h03;
        ie_en <= 8'hF0;
        ie_val <= 8'h30;
        sleep_active <= 1'b1;
        for (int m = 0; m < 5; m++) begin
            sleep_mode <= modes[m];
            exp8 = (m >= 2) ? 8'h33 : 8'h3F;
            @(negedge clock);
            check(raw, exp8, "sleep gate");
            @(posedge clock);
        end
        ext_int_en <= 8'h00;
        @(negedge clock);
        check(raw, 8'h30, "clamped");
        check(analog, 8'hFF, "analog unclamped");
        @(posedge clock);
        ie_en <= 8'h00;
        sleep_mode <= SLEEP_IDLE;
        @(negedge clock);
        check(raw, 8'hFF, "idle live");
        @(posedge clock);
        xfer(OFS_PIN_CHANGE, 1'b1, 32'hFF);
        sleep_mode <= SLEEP_POWER_DOWN;
        repeat (4) @(posedge clock);
        // Clear the flags raised on entry so only the wake edge is counted
        xfer(OFS_PIN_CHANGE, 1'b1, 32'hFF);
        sleep_active <= 1'b0;
        repeat (4) @(posedge clock);
        xfer(OFS_PIN_CHANGE, 1'b0, 32'h0);
        check(q, 32'hFF, "wake edge flags");
        xfer(8'h20, 1'b0, 32'h0);
        check(q, 32'h0, "unmapped");
        xfer(OFS_PIN_DIRECTION, 1'b1, 32'hFF);
        ext_en <= 8'h00;
        rst <= 1'b1;
        @(negedge clock);
        check({pad_oe, pad_out, pullup_en}, 24'h0, "mid-run reset");
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        xfer(OFS_PIN_DIRECTION, 1'b0, 32'h0);
        check(q, 32'h0, "direction after reset");
        wrap_up;
    end
endmodule
